// ---- tlic_ctrl.sv ----
// Two-level priority interrupt controller with AXI4-Lite register access.
`timescale 1ns/1ps
`include "tlic_consts.svh"

// What this block does
// - High vectors 0008h, low vectors 0018h.
// - Priority mode: high preempts running low handler.
// - Each source has flag, enable, priority bit.
// - Reset-control bit 7 turns priority mode on.
// - Bit 7 enables high, bit 6 low.
// - Flag, enable, group enable set: vector now.
// - Reset selects compatibility; priority bits ignored.
// - Compatibility: bit 6 peripherals, bit 7 all.
// - Compatibility: every interrupt uses vector 0008h.
// - Accepting clears the governing enable bit.
// - Running high handler holds off low requests.
// - Accept pushes return address, loads vector.
// - Return instruction sets governing enable again.
// - Pin events raise the request in six cycles, pulse inputs in three.
// - Flags set regardless of any enable.
// - Cleared source enable blocks only that source.
// - Flags stay set until software clears.
module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RESET_N,
  input  wire logic [N_SRC-1:0] EVENT_PIN,
  input  wire logic [N_SRC-1:0] EVENT_PULSE,
  input  wire logic             CORE_ACK,
  input  wire logic             CORE_RETURN,
  input  wire logic             CORE_IDLE,
  input  wire logic [11:0]      S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  input  wire logic [11:0]      S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY,
  output logic                  IRQ_REQ,
  output logic                  IRQ_HIGH,
  output logic [15:0]           IRQ_VECTOR,
  output logic                  CORE_WAKE
);
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]       irq_control_reg;
  logic [7:0]       reset_control_reg;
  logic [N_SRC-1:0] flag;
  logic [N_SRC-1:0] enable;
  logic [N_SRC-1:0] prio;
  logic [N_SRC-1:0] periph;
  logic             high_active;
  logic             low_active;
  tlic_irq_t        irq;
  wire logic        priority_mode_enable = reset_control_reg[`TLIC_BIT_PMODE];
  wire logic        high_group_enable    = irq_control_reg[`TLIC_BIT_HIGH_EN];
  wire logic        low_group_enable     = irq_control_reg[`TLIC_BIT_LOW_EN];

  // ****************************************************************
  // Event capture
  // ****************************************************************
  // Pins pass two flops and a registered edge detector, adding the three cycles that
  // make pin-to-request latency six cycles against three for pulse inputs.
  logic [N_SRC-1:0] pin_edge;
  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_sync
      tlic_sync u_sync (
        .clk        (SYS_CLK),
        .rst_n      (RESET_N),
        .async_in   (EVENT_PIN[gi]),
        .edge_pulse (pin_edge[gi])
      );
    end
  endgenerate
  wire logic [N_SRC-1:0] set_evt     = pin_edge | EVENT_PULSE;
  wire logic             core_ack    = CORE_ACK;
  wire logic             core_return = CORE_RETURN;
  wire logic             core_idle   = CORE_IDLE;

  // ****************************************************************
  // Request formation
  // ****************************************************************
  wire logic [N_SRC-1:0] armed     = flag & enable;
  wire logic             any_armed = |armed;
  logic                  high_req;
  logic                  low_req;
  logic                  compat_req;
  tlic_level_t           take;

  always_comb begin
    high_req   = 1'b0;
    low_req    = 1'b0;
    compat_req = 1'b0;
    take       = TLIC_NONE;
    if (priority_mode_enable) begin
      high_req = high_group_enable && |(armed & prio);
      low_req  = low_group_enable && |(armed & ~prio) && !high_active;
      if (high_req && !high_active) begin
        take = TLIC_HIGH;
      end else if (low_req && !low_active) begin
        take = TLIC_LOW;
      end
    end else begin
      compat_req = high_group_enable &&
                   (|(armed & ~periph) || (low_group_enable && |(armed & periph)));
      if (compat_req && !high_active) begin
        take = TLIC_HIGH;
      end
    end
  end

  // ****************************************************************
  // Handler tracking and core request
  // ****************************************************************
  // The request holds until the core acknowledges, which is when the core
  // pushes its return address and loads the presented vector.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq <= '0;
    end else if (irq.req) begin
      if (core_ack) begin
        irq <= '0;
      end
    end else if (take == TLIC_HIGH) begin
      irq.req    <= 1'b1;
      irq.high   <= 1'b1;
      irq.vector <= `TLIC_VEC_HIGH;
    end else if (take == TLIC_LOW) begin
      irq.req    <= 1'b1;
      irq.high   <= 1'b0;
      irq.vector <= `TLIC_VEC_LOW;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      high_active <= 1'b0;
      low_active  <= 1'b0;
    end else if (irq.req && core_ack) begin
      if (irq.high) begin
        high_active <= 1'b1;
      end else begin
        low_active <= 1'b1;
      end
    end else if (core_return) begin
      if (high_active) begin
        high_active <= 1'b0;
      end else begin
        low_active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  tlic_addr_t aw;
  logic       w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_hit;
  wire logic   wr_fire = aw.valid && w_held && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw            <= '0;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw.valid      <= 1'b1;
      aw.addr       <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_fire) begin
      aw.valid      <= 1'b0;
    end else if (!aw.valid && !S_AXI_BVALID) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held       <= 1'b1;
      w_data       <= S_AXI_WDATA;
      w_strb       <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_fire) begin
      w_held       <= 1'b0;
    end else if (!w_held && !S_AXI_BVALID) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_comb begin
    case ({aw.addr[11:2], 2'b00})
      `TLIC_OFF_CTRL, `TLIC_OFF_RSTCTL, `TLIC_OFF_FLAG, `TLIC_OFF_ENABLE,
      `TLIC_OFF_PRIO, `TLIC_OFF_PERIPH: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TLIC_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  wire logic wr_lane0  = wr_fire && w_strb[0];
  wire logic wr_ctrl   = wr_lane0 && ({aw.addr[11:2], 2'b00} == `TLIC_OFF_CTRL);
  wire logic wr_rstctl = wr_lane0 && ({aw.addr[11:2], 2'b00} == `TLIC_OFF_RSTCTL);
  wire logic wr_flag   = wr_lane0 && ({aw.addr[11:2], 2'b00} == `TLIC_OFF_FLAG);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Hardware edits of the enable bits win over a software write in the same
  // cycle only for the bit they touch, so a write never loses an accept or a return.
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = wr_ctrl ? w_data[7:0] : irq_control_reg;
    if (irq.req && core_ack) begin
      if (!priority_mode_enable || irq.high) begin
        next_ctrl[`TLIC_BIT_HIGH_EN] = 1'b0;
      end else begin
        next_ctrl[`TLIC_BIT_LOW_EN] = 1'b0;
      end
    end else if (core_return) begin
      if (!priority_mode_enable || high_active) begin
        next_ctrl[`TLIC_BIT_HIGH_EN] = 1'b1;
      end else begin
        next_ctrl[`TLIC_BIT_LOW_EN] = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_control_reg <= `TLIC_CTRL_RESET;
    end else begin
      irq_control_reg <= next_ctrl;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reset_control_reg <= `TLIC_RSTCTL_RESET;
    end else if (wr_rstctl) begin
      reset_control_reg <= w_data[7:0];
    end
  end

  // A write of zero clears a flag; a same-cycle event still sets it.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flag <= '0;
    end else begin
      flag <= (wr_flag ? (flag & w_data[N_SRC-1:0]) : flag) | set_evt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enable <= '0;
      prio   <= '0;
      periph <= '0;
    end else if (wr_lane0) begin
      case ({aw.addr[11:2], 2'b00})
        `TLIC_OFF_ENABLE: enable <= w_data[N_SRC-1:0];
        `TLIC_OFF_PRIO:   prio   <= w_data[N_SRC-1:0];
        `TLIC_OFF_PERIPH: periph <= w_data[N_SRC-1:0];
        default:          enable <= enable;
      endcase
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({S_AXI_ARADDR[11:2], 2'b00})
      `TLIC_OFF_CTRL:   rd_word[7:0] = irq_control_reg;
      `TLIC_OFF_RSTCTL: rd_word[7:0] = reset_control_reg;
      `TLIC_OFF_FLAG:   rd_word[N_SRC-1:0] = flag;
      `TLIC_OFF_ENABLE: rd_word[N_SRC-1:0] = enable;
      `TLIC_OFF_PRIO:   rd_word[N_SRC-1:0] = prio;
      `TLIC_OFF_PERIPH: rd_word[N_SRC-1:0] = periph;
      `TLIC_OFF_STATUS: begin
        rd_word[`TLIC_ST_HIGH_ACT] = high_active;
        rd_word[`TLIC_ST_LOW_ACT]  = low_active;
        rd_word[`TLIC_ST_REQ]      = irq.req;
        rd_word[`TLIC_ST_WAKE]     = CORE_WAKE;
        rd_word[`TLIC_ST_VEC_MSB:`TLIC_ST_VEC_LSB] = irq.vector;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `TLIC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= rd_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************************************
  // Core-facing outputs
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_REQ    <= 1'b0;
      IRQ_HIGH   <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
    end else begin
      IRQ_REQ    <= irq.req && !(core_ack && IRQ_REQ);
      IRQ_HIGH   <= irq.high;
      IRQ_VECTOR <= irq.vector;
    end
  end

  // Wake does not wait for the group enables; it needs an idle core and an armed source.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CORE_WAKE <= 1'b0;
    end else begin
      CORE_WAKE <= core_idle && any_armed;
    end
  end

endmodule // tlic_ctrl

// ---- tlic_consts.svh ----
// Offsets, field positions, reset values and timing counts of the two-level interrupt controller.
`ifndef TLIC_CONSTS_SVH
`define TLIC_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TLIC_OFF_CTRL      12'h000
`define TLIC_OFF_RSTCTL    12'h004
`define TLIC_OFF_FLAG      12'h008
`define TLIC_OFF_ENABLE    12'h00C
`define TLIC_OFF_PRIO      12'h010
`define TLIC_OFF_PERIPH    12'h014
`define TLIC_OFF_CORE      12'h018
`define TLIC_OFF_STATUS    12'h01C

// ****************************************************************
// Field positions
// ****************************************************************
`define TLIC_BIT_HIGH_EN    7
`define TLIC_BIT_LOW_EN     6
`define TLIC_BIT_PMODE      7
`define TLIC_CORE_ACK       0
`define TLIC_CORE_RETURN    1
`define TLIC_CORE_IDLE      2
`define TLIC_ST_HIGH_ACT    0
`define TLIC_ST_LOW_ACT     1
`define TLIC_ST_REQ         2
`define TLIC_ST_WAKE        3
`define TLIC_ST_VEC_LSB     8
`define TLIC_ST_VEC_MSB     23

// ****************************************************************
// Vectors, reset values and timing
// ****************************************************************
`define TLIC_VEC_HIGH       16'h0008
`define TLIC_VEC_LOW        16'h0018
`define TLIC_CTRL_RESET     8'h00
`define TLIC_RSTCTL_RESET   8'h00
`define TLIC_RESP_OKAY      2'h0
`define TLIC_RESP_SLVERR    2'h2
`define TLIC_LAT_CYCLES     3

`endif

// ---- tlic_pkg.sv ----
// Types shared by the two-level interrupt controller files.
package tlic_pkg;

  typedef struct packed {
    logic        req;
    logic        high;
    logic [15:0] vector;
  } tlic_irq_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
  } tlic_addr_t;

  typedef enum logic [1:0] {
    TLIC_NONE,
    TLIC_LOW,
    TLIC_HIGH
  } tlic_level_t;

endpackage

// ---- tlic_sync.sv ----
// Two-flop synchroniser with rising-edge detection for one external event line.
`timescale 1ns/1ps
module tlic_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      edge_pulse
);
  logic meta;
  logic stable;
  logic stable_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta     <= async_in;
      stable   <= meta;
      stable_d <= stable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= stable & ~stable_d;
    end
  end
endmodule // tlic_sync

// ---- tlic_ctrl_asserts.sv ----
// Port-level assertions for the two-level interrupt controller.
`timescale 1ns/1ps
module tlic_ctrl_asserts #(
  parameter int N_SRC = 8
) (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        CORE_ACK,
  input wire logic        CORE_RETURN,
  input wire logic        CORE_IDLE,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        IRQ_REQ,
  input wire logic        IRQ_HIGH,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic        CORE_WAKE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  // ****************
  // Handler tracking
  // ****************
  logic hi_busy;
  logic lo_busy;
  // Compatibility handlers always arrive marked high, so they are tracked as high.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) hi_busy <= 1'b0;
    else if (CORE_ACK && IRQ_REQ && IRQ_HIGH) hi_busy <= 1'b1;
    else if (CORE_RETURN) hi_busy <= 1'b0;
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) lo_busy <= 1'b0;
    else if (CORE_ACK && IRQ_REQ && !IRQ_HIGH) lo_busy <= 1'b1;
    else if (CORE_RETURN && !hi_busy) lo_busy <= 1'b0;
  end
  sequence s_acked;
    CORE_ACK && IRQ_REQ;
  endsequence
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  AST_VEC_MAP: assert property (IRQ_REQ |-> IRQ_VECTOR == (IRQ_HIGH ? 16'h0008 : 16'h0018))
    else $error("vector does not match level");
  AST_REQ_STANDS: assert property (IRQ_REQ && !CORE_ACK |=> IRQ_REQ)
    else $error("request withdrawn before acceptance");
  AST_ACK_DROPS: assert property (s_acked |=> !IRQ_REQ)
    else $error("request still up after acceptance");
  AST_HIGH_HOLDOFF: assert property (hi_busy |-> !IRQ_REQ)
    else $error("request during high handler");
  AST_LOW_HOLDOFF: assert property (lo_busy |-> !(IRQ_REQ && !IRQ_HIGH))
    else $error("low request during low handler");
  AST_WAKE_IDLE: assert property (!CORE_IDLE |=> !CORE_WAKE)
    else $error("wake while core not idle");
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
endmodule // tlic_ctrl_asserts

bind tlic_ctrl tlic_ctrl_asserts #(.N_SRC(N_SRC)) u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CORE_ACK(CORE_ACK), .CORE_RETURN(CORE_RETURN),
  .CORE_IDLE(CORE_IDLE), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .IRQ_REQ(IRQ_REQ), .IRQ_HIGH(IRQ_HIGH), .IRQ_VECTOR(IRQ_VECTOR), .CORE_WAKE(CORE_WAKE));

// ---- tlic_core_model.sv ----
// Behavioural processor core that accepts vectored interrupt requests.
`timescale 1ns/1ps
module tlic_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        ret_cmd,
  output logic             core_ack,
  output logic             core_return,
  output logic [15:0]      pc
);
  logic [3:0]  wait_cnt;
  logic [1:0]  depth;
  logic [15:0] stack_q [4];
  // The acceptance pulse lasts one cycle, so a request is never taken twice.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      wait_cnt <= 4'h0;
      depth    <= 2'h0;
      pc       <= 16'h0100;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_req && wait_cnt >= ack_delay) begin
      core_ack       <= 1'b1;
      stack_q[depth] <= pc;
      pc             <= irq_vector;
      depth          <= depth + 2'h1;
    end else if (irq_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else if (core_return) begin
      pc    <= stack_q[depth - 2'h1];
      depth <= depth - 2'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) core_return <= 1'b0;
    else core_return <= ret_cmd;
  end
endmodule // tlic_core_model

// ---- tb_top.sv ----
// Self-checking testbench for the two-level interrupt controller.
`timescale 1ns/1ps
`include "tlic_consts.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  ev_pin = 8'h00;
  logic [7:0]  ev_pulse = 8'h00;
  logic        idle = 1'b0;
  logic        ret_cmd = 1'b0;
  logic [3:0]  ack_dly = 4'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bready = 1'b0;
  logic        arv = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq_req, irq_high, core_wake, core_ack, core_ret;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [15:0] irq_vec, pc;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n;
  always #4 clk = ~clk;
  tlic_ctrl #(.N_SRC(8)) uut (
    .SYS_CLK(clk), .RESET_N(rst_n), .EVENT_PIN(ev_pin), .EVENT_PULSE(ev_pulse), .CORE_ACK(core_ack),
    .CORE_RETURN(core_ret), .CORE_IDLE(idle), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ_REQ(irq_req),
    .IRQ_HIGH(irq_high), .IRQ_VECTOR(irq_vec), .CORE_WAKE(core_wake));
  tlic_core_model core (
    .clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_vector(irq_vec), .ack_delay(ack_dly),
    .ret_cmd(ret_cmd), .core_ack(core_ack), .core_return(core_ret), .pc(pc));
  // ***********
  // Bus, event and core helpers
  // ***********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata  <= {24'h0, v};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(er));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a, `TLIC_RESP_OKAY);
    chk(d, e);
  endtask
  task automatic clr(input logic [7:0] keep);
    wr(`TLIC_OFF_FLAG, keep, `TLIC_RESP_OKAY);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev_pulse <= 8'h01 << i;
    @(posedge clk);
    ev_pulse <= 8'h00;
  endtask
  // Waits for a request, checks its level, then lets the core take it.
  task automatic take(input logic hi, input logic [15:0] v);
    n = 0;
    while (irq_req !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({n < 20, irq_high, irq_vec}, {1'b1, hi, v});
    n = 0;
    while (core_ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({n < 20, pc}, {1'b1, v});
  endtask
  task automatic quiet(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      if (irq_req !== 1'b0) n++;
    end
    chk(n, 0);
  endtask
  task automatic ret;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude;
    end
  end
  // *********
  // Scenarios
  // *********
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`TLIC_OFF_CTRL, 32'h0);
    rdc(`TLIC_OFF_RSTCTL, 32'h0);
    rd(12'h020, `TLIC_RESP_SLVERR);
    chk(d, 32'h0);
    wr(12'h024, 8'hFF, `TLIC_RESP_SLVERR);
    pulse(3);
    quiet(10);
    rdc(`TLIC_OFF_FLAG, 32'h08);
    clr(8'h00);
    rdc(`TLIC_OFF_FLAG, 32'h0);
    wr(`TLIC_OFF_ENABLE, 8'h03, `TLIC_RESP_OKAY);
    wr(`TLIC_OFF_PRIO, 8'h01, `TLIC_RESP_OKAY);
    wr(`TLIC_OFF_PERIPH, 8'h02, `TLIC_RESP_OKAY);
    wr(`TLIC_OFF_CTRL, 8'h80, `TLIC_RESP_OKAY);
    pulse(1);
    quiet(10);
    clr(8'h00);
    pulse(0);
    take(1'b1, `TLIC_VEC_HIGH);
    rdc(`TLIC_OFF_CTRL, 32'h00);
    clr(8'h00);
    ret;
    rdc(`TLIC_OFF_CTRL, 32'h80);
    wr(`TLIC_OFF_CTRL, 8'hC0, `TLIC_RESP_OKAY);
    pulse(1);
    take(1'b1, `TLIC_VEC_HIGH);
    clr(8'h00);
    ret;
    wr(`TLIC_OFF_ENABLE, 8'h06, `TLIC_RESP_OKAY);
    pulse(0);
    quiet(10);
    clr(8'h00);
    @(posedge clk);
    ev_pin <= 8'h04;
    n = 0;
    while (irq_req !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n inside {[3:8]}), 32'h1);
    take(1'b1, `TLIC_VEC_HIGH);
    ev_pin <= 8'h00;
    clr(8'h00);
    ret;
    wr(`TLIC_OFF_CTRL, 8'h00, `TLIC_RESP_OKAY);
    idle <= 1'b1;
    pulse(2);
    quiet(6);
    chk(32'(core_wake), 32'h1);
    idle <= 1'b0;
    clr(8'h00);
    ack_dly <= 4'h3;
    wr(`TLIC_OFF_RSTCTL, 8'h80, `TLIC_RESP_OKAY);
    rdc(`TLIC_OFF_RSTCTL, 32'h80);
    wr(`TLIC_OFF_ENABLE, 8'h03, `TLIC_RESP_OKAY);
    wr(`TLIC_OFF_CTRL, 8'h40, `TLIC_RESP_OKAY);
    pulse(0);
    quiet(10);
    clr(8'h00);
    wr(`TLIC_OFF_CTRL, 8'hC0, `TLIC_RESP_OKAY);
    pulse(1);
    take(1'b0, `TLIC_VEC_LOW);
    rdc(`TLIC_OFF_CTRL, 32'h80);
    pulse(0);
    take(1'b1, `TLIC_VEC_HIGH);
    rdc(`TLIC_OFF_CTRL, 32'h00);
    rdc(`TLIC_OFF_STATUS, 32'h0000_0003);
    clr(8'h00);
    ret;
    rdc(`TLIC_OFF_CTRL, 32'h80);
    ret;
    rdc(`TLIC_OFF_CTRL, 32'hC0);
    pulse(0);
    take(1'b1, `TLIC_VEC_HIGH);
    pulse(1);
    quiet(10);
    clr(8'h02);
    ret;
    take(1'b0, `TLIC_VEC_LOW);
    clr(8'h00);
    ret;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`TLIC_OFF_RSTCTL, 32'h0);
    rdc(`TLIC_OFF_CTRL, 32'h0);
    conclude;
  end
endmodule // tb_top
